// *** dps_pkg.sv ***
// Constants shared by the debug-port system control and status block.
// Assumes an 8-bit register path from the debug access layer.
package dps_pkg;
  // Register offsets on the access layer
  localparam logic [7:0] DPS_OFF_RESET_REQ = 8'h08;
  localparam logic [7:0] DPS_OFF_IF_CTRL = 8'h09;
  localparam logic [7:0] DPS_OFF_SYS_CTRL = 8'h0a;
  localparam logic [7:0] DPS_OFF_SYS_STATUS = 8'h0b;
  localparam logic [7:0] DPS_OFF_CRC_STATUS = 8'h0c;
  // System control field positions
  localparam int DPS_CTRL_CLOCK_REQUEST_BIT = 0;
  localparam int DPS_CTRL_FINAL_BIT = 1;
  // System status field positions
  localparam int DPS_STAT_LOCK_BIT = 0;
  localparam int DPS_STAT_UROW_BIT = 2;
  localparam int DPS_STAT_PROG_BIT = 3;
  localparam int DPS_STAT_SLEEP_BIT = 4;
  localparam int DPS_STAT_RST_BIT = 5;
  // Reset request read-back position
  localparam int DPS_RSTREQ_BIT = 0;
  // Reset values
  localparam logic [7:0] DPS_SYS_CTRL_RESET = 8'h00;
  localparam logic [7:0] DPS_SYS_STATUS_RESET = 8'h01;
  localparam logic [7:0] DPS_CRC_STATUS_RESET = 8'h00;
  localparam logic DPS_LOCK_RESET = 1'h1;
  // Interface clock select codes
  localparam logic [1:0] DPS_CLKSEL_RSVD = 2'h0;
  localparam logic [1:0] DPS_CLKSEL_16MHZ = 2'h1;
  localparam logic [1:0] DPS_CLKSEL_8MHZ = 2'h2;
  localparam logic [1:0] DPS_CLKSEL_4MHZ = 2'h3;
  // Reset request signature
  localparam logic [7:0] DPS_RESET_SIGNATURE = 8'h59;
  // Check engine status codes, one-hot
  localparam logic [2:0] DPS_CRC_OFF = 3'h0;
  localparam logic [2:0] DPS_CRC_BUSY = 3'h1;
  localparam logic [2:0] DPS_CRC_PASS = 3'h2;
  localparam logic [2:0] DPS_CRC_FAIL = 3'h4;
  // Synchronised status vector layout
  localparam int DPS_SYNC_WIDTH = 5;
endpackage

// *** dps_stat_if.sv ***
// Carrier for system-domain status after synchronisation.
// Assumes the synchroniser drives it and the control core only reads.
`timescale 1ns/1ps
`default_nettype none
interface dps_stat_if;
  logic sys_reset; // System domain held in reset
  logic sys_sleep; // System domain idle or deeper
  logic [2:0] crc; // Check engine status
  modport src (output sys_reset, output sys_sleep, output crc);
  modport dst (input sys_reset, input sys_sleep, input crc);
endinterface
`default_nettype wire

// *** dps_sync.sv ***
// Two-flop synchroniser for status coming from the system domain.
// Assumes inputs are asynchronous levels; codes change slowly enough to settle.
`timescale 1ns/1ps
`default_nettype none
module dps_sync
  import dps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sys_reset_i,
  input wire logic sys_sleep_i,
  input wire logic [2:0] crc_status_i,
  dps_stat_if.src stat
);
  // Both stages in one state word
  typedef struct packed {
    logic [DPS_SYNC_WIDTH-1:0] meta;
    logic [DPS_SYNC_WIDTH-1:0] safe;
  } dps_sync_state_t;

  dps_sync_state_t cur_reg; // Registered stages
  dps_sync_state_t cur_next; // Next stages

  // First stage feeds only the second stage
  always_comb begin
    cur_next = cur_reg;
    cur_next.meta = {crc_status_i, sys_sleep_i, sys_reset_i};
    cur_next.safe = cur_reg.meta;
  end

  // Synchronous reset clears both stages
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign stat.sys_reset = cur_reg.safe[0];
  assign stat.sys_sleep = cur_reg.safe[1];
  assign stat.crc = cur_reg.safe[4:2];
endmodule
`default_nettype wire

// *** dps_sticky.sv ***
// Sticky status flag, cleared by a read, where a set beats the clear.
// Assumes set and clear are same-clock pulses or levels.
`timescale 1ns/1ps
`default_nettype none
module dps_sticky (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  // Single flag word
  typedef struct packed {
    logic flag;
  } dps_sticky_state_t;

  dps_sticky_state_t cur_reg; // Held flag
  dps_sticky_state_t cur_next; // Next flag

  // Set wins so a reset seen during the read is not lost
  always_comb begin
    cur_next = cur_reg;
    cur_next.flag = set_i | (cur_reg.flag & ~clr_i);
  end

  // Flag register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign flag_o = cur_reg.flag;

  // A set always lands, even against a clear in the same cycle
  a_sticky_setwins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    set_i |=> flag_o) else $error("sticky flag missed a set");
  // A clear with no set empties the flag
  a_sticky_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (clr_i && !set_i) |=> !flag_o) else $error("sticky flag not cleared");
  // With neither strobe the flag keeps its value
  a_sticky_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!set_i && !clr_i) |=> flag_o == $past(flag_o)) else $error("sticky flag changed alone");
endmodule
`default_nettype wire

// *** dps_ctrl_status.sv ***
// Debug-port system control and status registers on the access layer.
// Assumes key status and ready levels come from same-clock debug logic,
// and that system reset, sleep and check status arrive asynchronously.
//
// Behaviour
// - Two-bit clock select, default 4 MHz.
// - Final bit write starts user-row flash write.
// - Final bit writable only with user-row key.
// - Clock request held while bit is one.
// - Enable sets clock request, disable clears.
// - Reset-active bit sticky, cleared on read.
// - Sleep bit mirrors system sleep state.
// - Programming-ready bit shows programming may start.
// - User-row-ready bit shows user-row programming allowed.
// - Lock bit resets one, follows lock.
// - Check status reported as one-hot code.
// - Signature write asserts reset, others release.
`timescale 1ns/1ps
`default_nettype none
module dps_ctrl_status
  import dps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic interface_enable_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic user_row_key_i,
  input wire logic programming_ready_i,
  input wire logic user_row_ready_i,
  input wire logic lock_i,
  input wire logic sys_reset_i,
  input wire logic sys_sleep_i,
  input wire logic [2:0] crc_status_i,
  output logic [1:0] interface_clock_select_o,
  output logic clock_request_o,
  output logic system_reset_req_o,
  output logic user_row_final_o
);
  import dps_pkg::*;

  // All control state in one word
  typedef struct packed {
    logic [1:0] clk_sel; // Interface clock code
    logic clk_req; // System clock request
    logic rst_req; // Reset held from request register
    logic row_final; // One-cycle user-row commit
    logic en_d; // Enable seen last cycle
    logic lock; // Lock state copy
    logic [7:0] rdata; // Read data
  } dps_ctrl_state_t;

  dps_ctrl_state_t cur_reg; // Registered state
  dps_ctrl_state_t cur_next; // Next state
  logic wr_ok; // Write allowed this cycle
  logic rd_status; // Read of system status
  logic rst_flag; // Sticky reset-active flag
  logic rst_set; // Any system reset source
  logic [7:0] status_val; // Assembled status byte
  logic [7:0] ctrl_val; // Assembled control byte
  logic row_commit; // Keyed write of the final bit

  dps_stat_if stat ();

  // System-domain levels are made safe before anything reads them
  dps_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sys_reset_i(sys_reset_i),
    .sys_sleep_i(sys_sleep_i),
    .crc_status_i(crc_status_i),
    .stat(stat)
  );

  // Reset from the system or from our own request both count
  assign rst_set = stat.sys_reset | cur_reg.rst_req;
  assign rd_status = reg_rd_i && (reg_addr_i == DPS_OFF_SYS_STATUS);

  // Reset-active flag survives until software has seen it
  dps_sticky u_rst_flag (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .set_i(rst_set),
    .clr_i(rd_status),
    .flag_o(rst_flag)
  );

  // Status byte, reserved bits read zero
  always_comb begin
    status_val = '0;
    status_val[DPS_STAT_RST_BIT] = rst_flag;
    status_val[DPS_STAT_SLEEP_BIT] = stat.sys_sleep;
    status_val[DPS_STAT_PROG_BIT] = programming_ready_i;
    status_val[DPS_STAT_UROW_BIT] = user_row_ready_i;
    status_val[DPS_STAT_LOCK_BIT] = cur_reg.lock;
  end

  // Control byte, upper bits are read-only zero
  always_comb begin
    ctrl_val = DPS_SYS_CTRL_RESET;
    ctrl_val[DPS_CTRL_CLOCK_REQUEST_BIT] = cur_reg.clk_req;
    ctrl_val[DPS_CTRL_FINAL_BIT] = cur_reg.row_final;
  end

  // Writes only land while the interface is up
  assign wr_ok = reg_wr_i && interface_enable_i;

  // Keyed final-bit write; the checks below measure the pulse against it
  assign row_commit = wr_ok && (reg_addr_i == DPS_OFF_SYS_CTRL)
    && reg_wdata_i[DPS_CTRL_FINAL_BIT] && user_row_key_i;

  // Next-state logic for every register and the read path
  always_comb begin
    cur_next = cur_reg;
    // Commit pulse lasts one cycle unless a new commit renews it
    cur_next.row_final = 1'h0;
    cur_next.en_d = interface_enable_i;
    cur_next.lock = lock_i;
    // Disabled interface drops back to its reset settings
    if (!interface_enable_i) begin
      cur_next.clk_sel = DPS_CLKSEL_4MHZ;
      cur_next.clk_req = 1'h0;
      cur_next.rst_req = 1'h0;
    end else if (!cur_reg.en_d) begin
      // Fresh enable raises the clock request by itself
      cur_next.clk_req = 1'h1;
    end
    // Register writes; read-only addresses fall through untouched
    if (wr_ok) begin
      case (reg_addr_i)
        DPS_OFF_SYS_CTRL: begin
          cur_next.clk_req = reg_wdata_i[DPS_CTRL_CLOCK_REQUEST_BIT];
          // Commit only once the user-row key is open
          if (reg_wdata_i[DPS_CTRL_FINAL_BIT] && user_row_key_i) begin
            cur_next.row_final = 1'h1;
          end
        end
        DPS_OFF_RESET_REQ: begin
          // Any value other than the signature releases the reset
          cur_next.rst_req = (reg_wdata_i == DPS_RESET_SIGNATURE);
        end
        DPS_OFF_IF_CTRL: begin
          // The reserved code would leave no clock, so it is refused
          if (reg_wdata_i[1:0] != DPS_CLKSEL_RSVD) begin
            cur_next.clk_sel = reg_wdata_i[1:0];
          end
        end
        default: begin
          // Status, check status and others ignore writes
          cur_next.clk_sel = cur_next.clk_sel;
        end
      endcase
    end
    // Read data is registered, so it appears one cycle after the strobe
    if (reg_rd_i) begin
      case (reg_addr_i)
        DPS_OFF_SYS_CTRL: begin
          cur_next.rdata = ctrl_val;
        end
        DPS_OFF_SYS_STATUS: begin
          cur_next.rdata = status_val;
        end
        DPS_OFF_CRC_STATUS: begin
          cur_next.rdata = {5'h00, stat.crc};
        end
        DPS_OFF_RESET_REQ: begin
          cur_next.rdata = '0;
          cur_next.rdata[DPS_RSTREQ_BIT] = cur_reg.rst_req;
        end
        DPS_OFF_IF_CTRL: begin
          cur_next.rdata = {6'h00, cur_reg.clk_sel};
        end
        default: begin
          // Unmapped offsets read as zero
          cur_next.rdata = '0;
        end
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cur_reg.clk_sel <= DPS_CLKSEL_4MHZ;
      cur_reg.clk_req <= 1'h0;
      cur_reg.rst_req <= 1'h0;
      cur_reg.row_final <= 1'h0;
      cur_reg.en_d <= 1'h0;
      cur_reg.lock <= DPS_LOCK_RESET;
      cur_reg.rdata <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Outputs come straight from flops
  assign interface_clock_select_o = cur_reg.clk_sel;
  assign clock_request_o = cur_reg.clk_req;
  assign system_reset_req_o = cur_reg.rst_req;
  assign user_row_final_o = cur_reg.row_final;
  assign reg_rdata_o = cur_reg.rdata;

  // Checks on the register behaviour, all on the one clock; reset
  // silences them except where the reset values themselves are checked
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Reset forces the slowest link clock
  a_clksel_reset: assert property (disable iff (1'h0)
    !rst_n_i |=> interface_clock_select_o == DPS_CLKSEL_4MHZ)
    else $error("clock select not 4 MHz after reset");
  // A legal code lands on the next edge
  a_clksel_write: assert property (
    (wr_ok && reg_addr_i == DPS_OFF_IF_CTRL && reg_wdata_i[1:0] != DPS_CLKSEL_RSVD)
    |=> interface_clock_select_o == $past(reg_wdata_i[1:0]))
    else $error("clock select write lost");
  // The reserved code would leave the link without a clock
  a_clksel_refused: assert property (
    (wr_ok && reg_addr_i == DPS_OFF_IF_CTRL && reg_wdata_i[1:0] == DPS_CLKSEL_RSVD)
    |=> $stable(interface_clock_select_o))
    else $error("reserved clock select taken");
  // Every keyed commit gives a pulse on the next edge, back to back too
  a_final_pulse: assert property (
    row_commit |=> user_row_final_o)
    else $error("user-row commit pulse missing");
  // A pulse needs a keyed commit one edge earlier, so it never stretches
  a_final_gated: assert property (
    user_row_final_o |-> $past(row_commit))
    else $error("user-row commit without key");
  // Request bit follows the written value
  a_clock_request_write: assert property (
    (wr_ok && reg_addr_i == DPS_OFF_SYS_CTRL)
    |=> clock_request_o == $past(reg_wdata_i[DPS_CTRL_CLOCK_REQUEST_BIT]))
    else $error("clock request write lost");
  // Fresh enable raises the request by itself
  a_clock_request_enable: assert property (
    (interface_enable_i && !cur_reg.en_d && !wr_ok) |=> clock_request_o)
    else $error("clock request not set on enable");
  // Disabled interface drops both requests
  a_clock_request_disable: assert property (
    !interface_enable_i |=> !clock_request_o && !system_reset_req_o)
    else $error("clock request kept while disabled");
  // Our own held reset shows in the next status read
  a_rst_visible: assert property (
    (system_reset_req_o ##1 (reg_rd_i && reg_addr_i == DPS_OFF_SYS_STATUS))
    |=> reg_rdata_o[DPS_STAT_RST_BIT])
    else $error("reset-active bit not seen");
  // Level status bits read as they stood at the read edge
  a_status_bits: assert property (
    rd_status |=> reg_rdata_o[DPS_STAT_SLEEP_BIT] == $past(stat.sys_sleep)
    && reg_rdata_o[DPS_STAT_PROG_BIT] == $past(programming_ready_i)
    && reg_rdata_o[DPS_STAT_UROW_BIT] == $past(user_row_ready_i)
    && reg_rdata_o[DPS_STAT_LOCK_BIT] == $past(cur_reg.lock))
    else $error("status bits mismatch");
  // Lock copy reads locked straight after reset
  a_lock_reset: assert property (disable iff (1'h0)
    !rst_n_i |=> cur_reg.lock)
    else $error("lock not set after reset");
  // Lock copy follows its input one edge later
  a_lock_follow: assert property (
    rst_n_i |=> cur_reg.lock == $past(lock_i))
    else $error("lock copy stale");
  // Check status reads back as synchronised
  a_crc_read: assert property (
    (reg_rd_i && reg_addr_i == DPS_OFF_CRC_STATUS)
    |=> reg_rdata_o == {5'h00, $past(stat.crc)})
    else $error("check status read wrong");
  // Signature holds the reset, any other value releases it
  a_reset_req: assert property (
    (wr_ok && reg_addr_i == DPS_OFF_RESET_REQ)
    |=> system_reset_req_o == ($past(reg_wdata_i) == DPS_RESET_SIGNATURE))
    else $error("reset request mismatch");
  // Only a request write or a disable moves the reset request
  a_reset_hold: assert property (
    (interface_enable_i && !(wr_ok && reg_addr_i == DPS_OFF_RESET_REQ))
    |=> $stable(system_reset_req_o))
    else $error("reset request moved without a write");
  // Control reads zero in read-only bits and the live request bit
  a_ctrl_readback: assert property (
    (reg_rd_i && reg_addr_i == DPS_OFF_SYS_CTRL)
    |=> reg_rdata_o[7:2] == 6'h00
    && reg_rdata_o[DPS_CTRL_CLOCK_REQUEST_BIT] == $past(clock_request_o))
    else $error("control read-back wrong");
  // Writes to status registers move no control output
  a_ro_ignored: assert property (
    (wr_ok && (reg_addr_i == DPS_OFF_SYS_STATUS || reg_addr_i == DPS_OFF_CRC_STATUS)
     && cur_reg.en_d)
    |=> $stable(clock_request_o) && $stable(system_reset_req_o)
    && $stable(interface_clock_select_o) && !user_row_final_o)
    else $error("read-only write changed state");

  // Main scenarios worth seeing at least once
  c_row_commit: cover property (user_row_final_o);
  c_sys_reset: cover property (system_reset_req_o ##1 !system_reset_req_o);
  c_fast_clock: cover property (interface_clock_select_o == DPS_CLKSEL_16MHZ);
  c_crc_fail: cover property (rd_status ##1 stat.crc == DPS_CRC_FAIL);
  c_reenable: cover property (!interface_enable_i ##1 interface_enable_i);
endmodule
`default_nettype wire

// *** dps_tool_model.sv ***
// Behavioural debugger model standing on the far side of the register path.
// Assumes strobes are sampled on the rising edge; it drives on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module dps_tool_model (
  input wire logic clk_i,
  input wire logic monitor_high_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  import dps_pkg::*;
  logic row_loaded; // Row data staged in RAM by the tool
  // Idle bus from time zero
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
    row_loaded = 1'b0;
  end
  // One-cycle write strobe; address and data held until the taking edge has passed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d; // Stale data no longer shown once released
  endtask
  // One-cycle read strobe; data is registered, so it is taken a half cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    rd_o = 1'b0;
    d = rdata_i;
  endtask
  // Faster clocks only with the supply monitor at its top level
  task automatic set_clock(input logic [1:0] code);
    logic [1:0] c;
    c = (monitor_high_i || code == DPS_CLKSEL_4MHZ) ? code : DPS_CLKSEL_4MHZ;
    wr(DPS_OFF_IF_CTRL, {6'h00, c});
  endtask
  // Row data first, then the final bit; clock request kept set
  task automatic commit_row();
    row_loaded = 1'b1;
    wr(DPS_OFF_SYS_CTRL, 8'h03);
    row_loaded = 1'b0;
  endtask
  // System reset after programming: signature holds, anything else releases
  task automatic reset_system(input logic hold);
    wr(DPS_OFF_RESET_REQ, hold ? DPS_RESET_SIGNATURE : 8'h00);
  endtask
endmodule
`default_nettype wire

// *** dps_ctrl_status_tb_top.sv ***
// Self-checking bench for the debug-port system control and status block.
// Assumes the tool model drives the register path and the bench drives all status.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module dps_ctrl_status_tb_top;
  import dps_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic en = 1'b1, key = 1'b0, prog = 1'b0, urow = 1'b0, lock = 1'b1;
  logic srst = 1'b0, sleep = 1'b0, mon = 1'b0;
  logic [2:0] crc = 3'h0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, fin, creq, rreq;
  logic [1:0] csel;
  int errors = 0;
  int n_compared = 0;
  logic [2:0] crc_tab [4] = '{DPS_CRC_OFF, DPS_CRC_BUSY, DPS_CRC_PASS, DPS_CRC_FAIL};
  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;
  dps_tool_model dps_tool_model_i (.clk_i(clk_i), .monitor_high_i(mon), .rdata_i(rdata),
    .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  dps_ctrl_status dps_ctrl_status_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .interface_enable_i(en), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .user_row_key_i(key),
    .programming_ready_i(prog), .user_row_ready_i(urow), .lock_i(lock),
    .sys_reset_i(srst), .sys_sleep_i(sleep), .crc_status_i(crc),
    .interface_clock_select_o(csel), .clock_request_o(creq),
    .system_reset_req_o(rreq), .user_row_final_o(fin));
  // Expected status byte from the inputs the bench drives
  function automatic logic [7:0] exp_status(logic r, logic s, logic p, logic u, logic l);
    return {2'h0, r, s, p, u, 1'b0, l};
  endfunction
  // Let status pass the synchronisers before reading
  task automatic settle();
    repeat (5) @(negedge clk_i);
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hang guard, well past the few hundred cycles the sequence needs
  initial begin
    #100000;
    errors++;
    complete_run();
  end
  // Main sequence
  initial begin
    void'($urandom(32'he9a8));
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    settle();
    // Values straight after reset with the interface enabled
    `CHK("csel reset", DPS_CLKSEL_4MHZ, csel)
    `CHK("creq on enable", 1'b1, creq)
    dps_tool_model_i.rd(DPS_OFF_SYS_STATUS, d);
    `CHK("status reset", DPS_SYS_STATUS_RESET, d)
    dps_tool_model_i.rd(DPS_OFF_CRC_STATUS, d);
    `CHK("crc reset", DPS_CRC_STATUS_RESET, d)
    // Low monitor: the tool keeps the slowest clock whatever it wants
    dps_tool_model_i.set_clock(DPS_CLKSEL_16MHZ);
    `CHK("csel monitor low", DPS_CLKSEL_4MHZ, csel)
    // Every clock code, then the reserved one refused
    mon = 1'b1;
    for (int c = 1; c <= 3; c++) begin
      dps_tool_model_i.set_clock(c[1:0]);
      `CHK("csel code", c[1:0], csel)
      dps_tool_model_i.rd(DPS_OFF_IF_CTRL, d);
      `CHK("csel read", c[1:0], d[1:0])
    end
    dps_tool_model_i.wr(DPS_OFF_IF_CTRL, 8'h00);
    `CHK("csel reserved", DPS_CLKSEL_4MHZ, csel)
    // Clock request withdrawn and read back as zero; read-only bits stay clear
    dps_tool_model_i.wr(DPS_OFF_SYS_CTRL, 8'hfc);
    `CHK("creq cleared", 1'b0, creq)
    dps_tool_model_i.rd(DPS_OFF_SYS_CTRL, d);
    `CHK("ctrl ro bits", 8'h00, d)
    // Final bit refused without the key, one pulse with it
    dps_tool_model_i.commit_row();
    `CHK("final no key", 1'b0, fin)
    `CHK("creq set", 1'b1, creq)
    key = 1'b1;
    dps_tool_model_i.commit_row();
    `CHK("final pulse", 1'b1, fin)
    @(negedge clk_i);
    `CHK("final ends", 1'b0, fin)
    key = 1'b0;
    // Own reset request held, reported, then released and cleared by reads
    dps_tool_model_i.reset_system(1'b1);
    `CHK("rreq held", 1'b1, rreq)
    dps_tool_model_i.rd(DPS_OFF_RESET_REQ, d);
    `CHK("rreq read", 8'h01, d)
    dps_tool_model_i.rd(DPS_OFF_SYS_STATUS, d);
    `CHK("rst active own", 1'b1, d[DPS_STAT_RST_BIT])
    dps_tool_model_i.reset_system(1'b0);
    `CHK("rreq released", 1'b0, rreq)
    dps_tool_model_i.rd(DPS_OFF_SYS_STATUS, d);
    dps_tool_model_i.rd(DPS_OFF_SYS_STATUS, d);
    `CHK("rst cleared", 1'b0, d[DPS_STAT_RST_BIT])
    // System-domain reset seen through the synchroniser
    srst = 1'b1;
    settle();
    srst = 1'b0;
    settle();
    dps_tool_model_i.rd(DPS_OFF_SYS_STATUS, d);
    `CHK("rst sys sticky", 1'b1, d[DPS_STAT_RST_BIT])
    dps_tool_model_i.rd(DPS_OFF_SYS_STATUS, d);
    `CHK("rst sys cleared", 1'b0, d[DPS_STAT_RST_BIT])
    // Random status levels and every check code; status writes ignored
    for (int i = 0; i < 12; i++) begin
      {sleep, prog, urow, lock} = 4'($urandom());
      crc = crc_tab[i % 4];
      settle();
      dps_tool_model_i.wr(DPS_OFF_SYS_STATUS, 8'($urandom()));
      dps_tool_model_i.wr(DPS_OFF_CRC_STATUS, 8'hff);
      dps_tool_model_i.rd(DPS_OFF_SYS_STATUS, d);
      `CHK("status", exp_status(1'b0, sleep, prog, urow, lock), d)
      dps_tool_model_i.rd(DPS_OFF_CRC_STATUS, d);
      `CHK("crc", {5'h00, crc}, d)
    end
    dps_tool_model_i.rd(8'h20, d);
    `CHK("unmapped", 8'h00, d)
    // Disable drops the request and restores defaults; writes then ignored
    dps_tool_model_i.set_clock(DPS_CLKSEL_16MHZ);
    en = 1'b0;
    repeat (2) @(negedge clk_i);
    dps_tool_model_i.reset_system(1'b1);
    `CHK("creq disabled", 1'b0, creq)
    `CHK("csel disabled", DPS_CLKSEL_4MHZ, csel)
    `CHK("rreq disabled", 1'b0, rreq)
    en = 1'b1;
    repeat (3) @(negedge clk_i);
    `CHK("creq reenable", 1'b1, creq)
    complete_run();
  end
endmodule
`undef CHK
`default_nettype wire
